/* core/trim_defs.svh */
`ifndef TRIM_DEFS_SVH
`define TRIM_DEFS_SVH

// Register indices; the APB byte address is four times the index.
`define STATUS_IDX 10'h2C1
`define MASK_IDX 10'h2C2
`define LANE_ALM_IDX 10'h2C4
`define TRIM_A_DUAL_IDX 10'h310
`define TRIM_B_DUAL_IDX 10'h313
`define TRIM_A_SINGLE_IDX 10'h314

// Widths.
`define ADDR_W 12
`define IDX_W 10
`define STATUS_W 6
`define LANE_W 16
`define TRIM_W 8
`define OTHER_ALM_W 5

// Reset values.
`define STATUS_RST 6'h3F
`define MASK_RST 6'h3F
`define LANE_ALM_RST 16'hFFFF
`define TRIM_RST 8'h00

// Field positions.
`define FIFO_SUMMARY_ALARM_BIT 5
`define IDX_LSB 2

`endif

/* core/trim_pkg.sv */
package trim_pkg;

`include "trim_defs.svh"

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } apb_rsp_t;

    typedef enum logic [2:0] {
        REG_NONE,
        REG_STATUS,
        REG_MASK,
        REG_LANE,
        REG_TRIM_A_DUAL,
        REG_TRIM_B_DUAL,
        REG_TRIM_A_SINGLE
    } reg_id_t;

    typedef struct packed {
        logic dual;
        logic fg_cal;
        logic input_b;
    } mode_t;

    typedef struct packed {
        logic [`TRIM_W-1:0] a_dual;
        logic [`TRIM_W-1:0] b_dual;
        logic [`TRIM_W-1:0] a_single;
    } trim_set_t;

    typedef struct packed {
        logic valid;
        logic [`TRIM_W-1:0] value;
    } trim_out_t;

    typedef struct packed {
        logic [`LANE_W-1:0] lane_alarm;
    } lane_state_t;

    typedef struct packed {
        logic [`STATUS_W-1:0] status;
        logic [`STATUS_W-1:0] mask;
        trim_set_t trims;
        logic fuse_done;
        apb_rsp_t rsp;
        trim_out_t a_out;
        trim_out_t b_out;
        logic alarm;
    } main_state_t;

endpackage

/* core/lane_fifo_alarm_vec.sv */
`timescale 1ns/1ps
`include "trim_defs.svh"

module lane_fifo_alarm_vec
    import trim_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [`LANE_W-1:0] lane_err_in,
    input wire logic [`LANE_W-1:0] clr_bits_in,
    input wire logic clr_all_in,
    output logic [`LANE_W-1:0] lane_alarm_out
);

    lane_state_t st_r;
    lane_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Each lane bit clears on a one and sets again while its lane still errs.
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < `LANE_W; i++) begin
            if (lane_err_in[i]) begin
                st_nxt.lane_alarm[i] = 1'b1;
            end else if (clr_all_in || clr_bits_in[i]) begin
                st_nxt.lane_alarm[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r.lane_alarm <= `LANE_ALM_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lane_alarm_out = st_r.lane_alarm;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_keep_unwritten;
        @(posedge clk_in) disable iff (rst_in)
        (clr_bits_in == 16'h0000 && !clr_all_in) |=>
            ((lane_alarm_out & $past(lane_alarm_out)) == $past(lane_alarm_out));
    endproperty
    a_keep_unwritten: assert property (p_keep_unwritten) else $error("lane bit lost");

endmodule

/* core/lane_fifo_alarm_and_timing_trim.sv */
`timescale 1ns/1ps
`include "trim_defs.svh"


module lane_fifo_alarm_and_timing_trim
    import trim_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire apb_req_t APB_REQ_IN,
    output apb_rsp_t APB_RSP_OUT,
    input wire logic [`LANE_W-1:0] LANE_FIFO_ERR_IN,
    input wire logic [`OTHER_ALM_W-1:0] OTHER_ALARM_IN,
    input wire trim_set_t FUSE_TRIM_IN,
    input wire mode_t MODE_IN,
    output trim_out_t CORE_A_TRIM_OUT,
    output trim_out_t CORE_B_TRIM_OUT,
    output logic ALARM_OUT
);

    main_state_t st_r;
    main_state_t st_nxt;
    logic [`LANE_W-1:0] lane_alarm;
    logic [`LANE_W-1:0] lane_clr;
    logic clr_all;
    logic wr_done;
    logic rd_done;
    reg_id_t wsel;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the read and the write path.
    function automatic reg_id_t reg_decode(input logic [`ADDR_W-1:0] addr);
        reg_id_t id;
        logic [`IDX_W-1:0] idx;
        idx = addr[`ADDR_W-1:`IDX_LSB];
        if (addr[`IDX_LSB-1:0] != 2'h0) begin
            id = REG_NONE;
        end else if (idx == `STATUS_IDX) begin
            id = REG_STATUS;
        end else if (idx == `MASK_IDX) begin
            id = REG_MASK;
        end else if (idx == `LANE_ALM_IDX) begin
            id = REG_LANE;
        end else if (idx == `TRIM_A_DUAL_IDX) begin
            id = REG_TRIM_A_DUAL;
        end else if (idx == `TRIM_B_DUAL_IDX) begin
            id = REG_TRIM_B_DUAL;
        end else if (idx == `TRIM_A_SINGLE_IDX) begin
            id = REG_TRIM_A_SINGLE;
        end else begin
            id = REG_NONE;
        end
        return id;
    endfunction

    // Read data for one register; unused upper bits read as zero.
    function automatic logic [31:0] read_word(
        input reg_id_t id,
        input main_state_t st,
        input logic [`LANE_W-1:0] lanes
    );
        logic [31:0] w;
        w = 32'h00000000;
        case (id)
            REG_STATUS: begin
                w[`STATUS_W-1:0] = st.status;
            end
            REG_MASK: begin
                w[`STATUS_W-1:0] = st.mask;
            end
            REG_LANE: begin
                w[`LANE_W-1:0] = lanes;
            end
            REG_TRIM_A_DUAL: begin
                w[`TRIM_W-1:0] = st.trims.a_dual;
            end
            REG_TRIM_B_DUAL: begin
                w[`TRIM_W-1:0] = st.trims.b_dual;
            end
            REG_TRIM_A_SINGLE: begin
                w[`TRIM_W-1:0] = st.trims.a_single;
            end
            default: begin
                w = 32'h00000000;
            end
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Completed APB transfers and the clear strobes that writes produce.
    assign wsel = reg_decode(APB_REQ_IN.paddr);
    assign wr_done = APB_REQ_IN.psel & APB_REQ_IN.penable & st_r.rsp.pready & APB_REQ_IN.pwrite;
    assign rd_done = APB_REQ_IN.psel & APB_REQ_IN.penable & st_r.rsp.pready & ~APB_REQ_IN.pwrite;
    assign lane_clr = (wr_done && wsel == REG_LANE) ? APB_REQ_IN.pwdata[`LANE_W-1:0]
                                                    : 16'h0000;
    assign clr_all = wr_done && wsel == REG_STATUS && APB_REQ_IN.pwdata[`FIFO_SUMMARY_ALARM_BIT];

    lane_fifo_alarm_vec u_lane_alarm (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .lane_err_in(LANE_FIFO_ERR_IN),
        .clr_bits_in(lane_clr),
        .clr_all_in(clr_all),
        .lane_alarm_out(lane_alarm)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the register slice.
    always_comb begin
        logic [`STATUS_W-1:0] st_clr;
        logic [`STATUS_W-1:0] st_set;
        logic single_a;
        st_clr = '0;
        st_set = {|LANE_FIFO_ERR_IN, OTHER_ALARM_IN};
        single_a = 1'b0;
        st_nxt = st_r;

        // Slave answers in the first access cycle; data is prepared in setup.
        st_nxt.rsp.pready = 1'b0;
        st_nxt.rsp.prdata = 32'h00000000;
        st_nxt.rsp.pslverr = 1'b0;
        if (APB_REQ_IN.psel && !APB_REQ_IN.penable) begin
            st_nxt.rsp.pready = 1'b1;
            st_nxt.rsp.prdata = read_word(wsel, st_r, lane_alarm);
            st_nxt.rsp.pslverr = (wsel == REG_NONE);
        end

        // Status bits are write one to clear, with new events winning.
        if (wr_done && wsel == REG_STATUS) begin
            st_clr = APB_REQ_IN.pwdata[`STATUS_W-1:0];
        end
        st_nxt.status = (st_r.status & ~st_clr) | st_set;
        if (wr_done && wsel == REG_MASK) begin
            st_nxt.mask = APB_REQ_IN.pwdata[`STATUS_W-1:0];
        end

        // Factory trims load once after reset; software may overwrite later.
        if (!st_r.fuse_done) begin
            st_nxt.trims = FUSE_TRIM_IN;
            st_nxt.fuse_done = 1'b1;
        end else if (wr_done) begin
            if (wsel == REG_TRIM_A_DUAL) begin
                st_nxt.trims.a_dual = APB_REQ_IN.pwdata[`TRIM_W-1:0];
            end else if (wsel == REG_TRIM_B_DUAL) begin
                st_nxt.trims.b_dual = APB_REQ_IN.pwdata[`TRIM_W-1:0];
            end else if (wsel == REG_TRIM_A_SINGLE) begin
                st_nxt.trims.a_single = APB_REQ_IN.pwdata[`TRIM_W-1:0];
            end
        end

        // Each trim drives only the core and mode it governs.
        single_a = !MODE_IN.dual && MODE_IN.fg_cal && !MODE_IN.input_b;
        st_nxt.a_out.valid = MODE_IN.dual || single_a;
        if (MODE_IN.dual) begin
            st_nxt.a_out.value = st_r.trims.a_dual;
        end else if (single_a) begin
            st_nxt.a_out.value = st_r.trims.a_single;
        end else begin
            st_nxt.a_out.value = `TRIM_RST;
        end
        st_nxt.b_out.valid = MODE_IN.dual && MODE_IN.fg_cal;
        st_nxt.b_out.value = st_nxt.b_out.valid ? st_r.trims.b_dual : `TRIM_RST;

        st_nxt.alarm = |(st_r.status & ~st_r.mask);
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_r.status <= `STATUS_RST;
            st_r.mask <= `MASK_RST;
            st_r.trims <= {`TRIM_RST, `TRIM_RST, `TRIM_RST};
            st_r.fuse_done <= 1'b0;
            st_r.rsp <= '0;
            st_r.a_out <= '0;
            st_r.b_out <= '0;
            st_r.alarm <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign APB_RSP_OUT = st_r.rsp;
    assign CORE_A_TRIM_OUT = st_r.a_out;
    assign CORE_B_TRIM_OUT = st_r.b_out;
    assign ALARM_OUT = st_r.alarm;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    property p_apb_ready;
        (APB_REQ_IN.psel && !APB_REQ_IN.penable) |=> APB_RSP_OUT.pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no ready in access");

    property p_lane_set;
        (LANE_FIFO_ERR_IN != 16'h0000) |=>
            ((lane_alarm & $past(LANE_FIFO_ERR_IN)) == $past(LANE_FIFO_ERR_IN));
    endproperty
    a_lane_set: assert property (p_lane_set) else $error("lane bit not set");

    property p_lane_w1c;
        (lane_clr != 16'h0000 && LANE_FIFO_ERR_IN == 16'h0000 && !clr_all) |=>
            (lane_alarm == ($past(lane_alarm) & ~$past(lane_clr)));
    endproperty
    a_lane_w1c: assert property (p_lane_w1c) else $error("lane clear wrong");

    property p_set_beats_clear;
        ((lane_clr & LANE_FIFO_ERR_IN) != 16'h0000) |=>
            ((lane_alarm & $past(lane_clr & LANE_FIFO_ERR_IN)) != 16'h0000);
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat set");

    property p_clear_all;
        (clr_all && LANE_FIFO_ERR_IN == 16'h0000) |=> (lane_alarm == 16'h0000);
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("bulk clear failed");

    property p_lane_reset;
        !st_r.fuse_done |-> (lane_alarm == `LANE_ALM_RST);
    endproperty
    a_lane_reset: assert property (p_lane_reset) else $error("lane reset value wrong");

    property p_fuse_load;
        (!RST_IN && !st_r.fuse_done) |=>
            (st_r.fuse_done && st_r.trims == $past(FUSE_TRIM_IN));
    endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("factory trim not loaded");

    property p_trim_write;
        (wr_done && wsel == REG_TRIM_B_DUAL && st_r.fuse_done) |=>
            (st_r.trims.b_dual == $past(APB_REQ_IN.pwdata[7:0]));
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim write lost");

    property p_read_clean;
        rd_done |=> ((lane_alarm & $past(lane_alarm)) == $past(lane_alarm));
    endproperty
    a_read_clean: assert property (p_read_clean) else $error("read changed alarms");

    property p_route_a_dual;
        MODE_IN.dual |=> (CORE_A_TRIM_OUT.valid &&
            CORE_A_TRIM_OUT.value == $past(st_r.trims.a_dual));
    endproperty
    a_route_a_dual: assert property (p_route_a_dual) else $error("core A dual trim");

    property p_route_b_dual;
        (MODE_IN.dual && MODE_IN.fg_cal) |=> (CORE_B_TRIM_OUT.valid &&
            CORE_B_TRIM_OUT.value == $past(st_r.trims.b_dual));
    endproperty
    a_route_b_dual: assert property (p_route_b_dual) else $error("core B dual trim");

    property p_route_a_single;
        (!MODE_IN.dual && MODE_IN.fg_cal && !MODE_IN.input_b) |=>
            (CORE_A_TRIM_OUT.valid && CORE_A_TRIM_OUT.value == $past(st_r.trims.a_single));
    endproperty
    a_route_a_single: assert property (p_route_a_single) else $error("core A single");

    property p_route_none;
        (!MODE_IN.dual && (!MODE_IN.fg_cal || MODE_IN.input_b)) |=>
            (!CORE_A_TRIM_OUT.valid && !CORE_B_TRIM_OUT.valid);
    endproperty
    a_route_none: assert property (p_route_none) else $error("trim leaked");

    property p_fifo_summary;
        (LANE_FIFO_ERR_IN != 16'h0000) |=> st_r.status[`FIFO_SUMMARY_ALARM_BIT];
    endproperty
    a_fifo_summary: assert property (p_fifo_summary) else $error("summary not set");

    property p_alarm_out;
        (st_r.status[`FIFO_SUMMARY_ALARM_BIT] && !st_r.mask[`FIFO_SUMMARY_ALARM_BIT]) |=> ALARM_OUT;
    endproperty
    a_alarm_out: assert property (p_alarm_out) else $error("alarm output low");

    property p_alarm_low;
        ((st_r.status & ~st_r.mask) == 6'h00) |=> !ALARM_OUT;
    endproperty
    a_alarm_low: assert property (p_alarm_low) else $error("alarm output high");

    property p_mask_write;
        (wr_done && wsel == REG_MASK) |=> (st_r.mask == $past(APB_REQ_IN.pwdata[5:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    property p_status_w1c;
        (wr_done && wsel == REG_STATUS && LANE_FIFO_ERR_IN == 16'h0000 &&
            OTHER_ALARM_IN == 5'h00) |=>
            (st_r.status == ($past(st_r.status) & ~$past(APB_REQ_IN.pwdata[5:0])));
    endproperty
    a_status_w1c: assert property (p_status_w1c) else $error("status clear wrong");

    property p_trim_wr_a;
        (wr_done && wsel == REG_TRIM_A_DUAL && st_r.fuse_done) |=>
            (st_r.trims.a_dual == $past(APB_REQ_IN.pwdata[7:0]));
    endproperty
    a_trim_wr_a: assert property (p_trim_wr_a) else $error("trim A write lost");

    property p_trim_wr_s;
        (wr_done && wsel == REG_TRIM_A_SINGLE && st_r.fuse_done) |=>
            (st_r.trims.a_single == $past(APB_REQ_IN.pwdata[7:0]));
    endproperty
    a_trim_wr_s: assert property (p_trim_wr_s) else $error("single trim write lost");

    property p_route_b_none;
        !(MODE_IN.dual && MODE_IN.fg_cal) |=>
            (!CORE_B_TRIM_OUT.valid && CORE_B_TRIM_OUT.value == `TRIM_RST);
    endproperty
    a_route_b_none: assert property (p_route_b_none) else $error("core B trim leaked");

    property p_unmapped;
        (APB_REQ_IN.psel && !APB_REQ_IN.penable && wsel == REG_NONE) |=>
            (APB_RSP_OUT.pslverr && APB_RSP_OUT.prdata == 32'h00000000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_rsp_one;
        APB_RSP_OUT.pready |=> !APB_RSP_OUT.pready;
    endproperty
    a_rsp_one: assert property (p_rsp_one) else $error("ready stood too long");

    property p_rsp_idle;
        !APB_RSP_OUT.pready |-> (APB_RSP_OUT.prdata == 32'h00000000 && !APB_RSP_OUT.pslverr);
    endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("response without ready");

    c_lane_clear: cover property (lane_clr != 16'h0000);
    c_clear_all: cover property (clr_all);
    c_dual_mode: cover property (MODE_IN.dual && MODE_IN.fg_cal);
    c_single_a: cover property (!MODE_IN.dual && MODE_IN.fg_cal && !MODE_IN.input_b);
    c_alarm_out: cover property (ALARM_OUT);

endmodule

/* tb/lane_fifo_alarm_and_timing_trim_tb.sv */
`timescale 1ns/1ps
`include "trim_defs.svh"

module lane_fifo_alarm_and_timing_trim_tb
    import trim_pkg::*;
;
    logic clk;
    logic rst;
    apb_req_t req;
    apb_rsp_t rsp;
    logic [`LANE_W-1:0] err;
    logic [`OTHER_ALM_W-1:0] oth;
    trim_set_t fuse;
    trim_set_t tr;
    mode_t mode;
    trim_out_t a_out;
    trim_out_t b_out;
    logic alarm;
    int n_mismatch;
    int check_count;
    int seed;
    logic [31:0] rd;
    logic [31:0] p;
    logic se;

    ////////////////////////////////////////////////////////////////////////////////
    lane_fifo_alarm_and_timing_trim u_dut (
        .SYS_CLK_IN(clk),
        .RST_IN(rst),
        .APB_REQ_IN(req),
        .APB_RSP_OUT(rsp),
        .LANE_FIFO_ERR_IN(err),
        .OTHER_ALARM_IN(oth),
        .FUSE_TRIM_IN(fuse),
        .MODE_IN(mode),
        .CORE_A_TRIM_OUT(a_out),
        .CORE_B_TRIM_OUT(b_out),
        .ALARM_OUT(alarm)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, wd};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        se = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (rsp.pready !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t no ready", $time);
            end_sim();
        end
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk({31'h0, se}, 32'h0);
        chk(rd, exp);
    endtask

    function automatic trim_out_t exp_a(input logic [2:0] m);
        if (m[2]) return '{1'b1, tr.a_dual};
        if (m[1] && !m[0]) return '{1'b1, tr.a_single};
        return '{1'b0, 8'h00};
    endfunction

    function automatic trim_out_t exp_b(input logic [2:0] m);
        if (m[2] && m[1]) return '{1'b1, tr.b_dual};
        return '{1'b0, 8'h00};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 12694;
        n_mismatch = 0;
        check_count = 0;
        rst = 1'b1;
        req = '0;
        err = '0;
        oth = '0;
        mode = '0;
        fuse = trim_set_t'(24'($random(seed)));
        tr = fuse;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdchk(`LANE_ALM_IDX, 32'h0000FFFF);
        rdchk(`STATUS_IDX, 32'h3F);
        rdchk(`MASK_IDX, 32'h3F);
        rdchk(`TRIM_A_DUAL_IDX, {24'h0, tr.a_dual});
        rdchk(`TRIM_B_DUAL_IDX, {24'h0, tr.b_dual});
        rdchk(`TRIM_A_SINGLE_IDX, {24'h0, tr.a_single});
        chk({31'h0, alarm}, 32'h0);
        $display("reset test done");

        p = $random(seed);
        apb(1'b1, `LANE_ALM_IDX, p);
        rdchk(`LANE_ALM_IDX, {16'h0, ~p[15:0]});
        apb(1'b1, `LANE_ALM_IDX, 32'hFFFF);
        rdchk(`LANE_ALM_IDX, 32'h0);
        @(posedge clk);
        err <= 16'h0008;
        @(posedge clk);
        apb(1'b1, `LANE_ALM_IDX, 32'hFFFF);
        rdchk(`LANE_ALM_IDX, 32'h8);
        err <= 16'h0;
        apb(1'b1, `LANE_ALM_IDX, 32'hFFFF);
        rdchk(`LANE_ALM_IDX, 32'h0);
        $display("clear test done");

        apb(1'b1, `MASK_IDX, 32'h1F);
        rdchk(`MASK_IDX, 32'h1F);
        apb(1'b1, `STATUS_IDX, 32'h3F);
        repeat (3) @(posedge clk);
        chk({31'h0, alarm}, 32'h0);
        p = $random(seed);
        if (p[15:0] == 16'h0) p = 32'h1;
        err <= p[15:0];
        @(posedge clk);
        err <= 16'h0;
        repeat (3) @(posedge clk);
        chk({31'h0, alarm}, 32'h1);
        rdchk(`LANE_ALM_IDX, {16'h0, p[15:0]});
        rdchk(`STATUS_IDX, 32'h20);
        rdchk(`LANE_ALM_IDX, {16'h0, p[15:0]});
        apb(1'b1, `STATUS_IDX, 32'h20);
        rdchk(`LANE_ALM_IDX, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, alarm}, 32'h0);
        oth <= 5'h15;
        @(posedge clk);
        oth <= 5'h0;
        rdchk(`STATUS_IDX, 32'h15);
        apb(1'b0, 10'h000, 32'h0);
        chk({31'h0, se}, 32'h1);
        chk(rd, 32'h0);
        $display("alarm test done");

        p = $random(seed);
        apb(1'b1, `TRIM_A_DUAL_IDX, p);
        tr.a_dual = p[7:0];
        p = $random(seed);
        apb(1'b1, `TRIM_B_DUAL_IDX, p);
        tr.b_dual = p[7:0];
        p = $random(seed);
        apb(1'b1, `TRIM_A_SINGLE_IDX, p);
        tr.a_single = p[7:0];
        rdchk(`TRIM_A_DUAL_IDX, {24'h0, tr.a_dual});
        rdchk(`TRIM_B_DUAL_IDX, {24'h0, tr.b_dual});
        rdchk(`TRIM_A_SINGLE_IDX, {24'h0, tr.a_single});
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            mode <= mode_t'(m[2:0]);
            repeat (3) @(posedge clk);
            chk({23'h0, a_out}, {23'h0, exp_a(m[2:0])});
            chk({23'h0, b_out}, {23'h0, exp_b(m[2:0])});
        end
        @(posedge clk);
        mode <= mode_t'(3'b100);
        apb(1'b1, `TRIM_A_DUAL_IDX, 32'h5A);
        tr.a_dual = 8'h5A;
        repeat (3) @(posedge clk);
        chk({23'h0, a_out}, {23'h0, exp_a(3'b100)});
        $display("trim test done");
        mode <= '0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        tr = fuse;
        rdchk(`LANE_ALM_IDX, 32'h0000FFFF);
        rdchk(`TRIM_B_DUAL_IDX, {24'h0, tr.b_dual});
        chk({23'h0, a_out}, 32'h0);
        $display("second reset test done");
        end_sim();
    end
endmodule
